// *** common/satc_defs.svh ***
`ifndef SATC_DEFS_SVH
`define SATC_DEFS_SVH

// ==========================================================================
// Register indices; the byte address is four times the index.
// ==========================================================================
`define SATC_IDX_PWR 16'hF051
`define SATC_IDX_RDY 16'hF60F
`define SATC_IDX_CS_R 16'hF620
`define SATC_IDX_UD_L 16'hF630
`define SATC_IDX_UD_R 16'hF640
`define SATC_IDX_VB_L 16'hF650
`define SATC_IDX_VB_R 16'hF660
`define SATC_IDX_PB_L 16'hF670
`define SATC_IDX_PB_R 16'hF680
`define SATC_IDX_TX_EN 16'hF690
`define SATC_IDX_TX_CTRL 16'hF691
`define SATC_IDX_IRQ_STAT 16'hF700
`define SATC_IDX_IRQ_EN 16'hF701
`define SATC_IDX_IRQ_CLR 16'hF702
`define SATC_BANK_STRIDE 16'h0010

// ==========================================================================
// Geometry, fields and reset values.
// ==========================================================================
`define SATC_NBANKS 7
`define SATC_BANK_WORDS 12
`define SATC_FRAMES 192
`define SATC_LAST_FRAME 8'hBF
`define SATC_TX_OUTPUT_ON_BIT 0
`define SATC_TXPWR_BIT 2
`define SATC_RST_ZERO 16'h0000
`define SATC_PWR_RST 16'h0000
`define SATC_MAX_WL 24
`define SATC_MASK_24 24'hFFFFFF
`define SATC_MASK_20 24'hFFFFF0
`define SATC_MASK_16 24'hFFFF00
`define SATC_CS_MAXLEN_BIT 32
`define SATC_CS_LEN_LO 33
`define SATC_CS_CODE_SHORT 3'h1
`define SATC_IRQ_DONE_BIT 0
`define SATC_IRQ_SYNC_BIT 1
`define SATC_RESP_OKAY 2'h0
`define SATC_RESP_SLVERR 2'h2

`endif

// *** common/satc_pkg.sv ***
package satc_pkg;
   typedef enum logic [1:0] {
      SATC_WL_24,
      SATC_WL_20,
      SATC_WL_16,
      SATC_WL_AUTO
   } satc_wlen_e;
   typedef logic [15:0] satc_word_t;
endpackage : satc_pkg

// *** hw/satc_top.sv ***
`timescale 1ns/1ps
`include "satc_defs.svh"

module satc_top #(
   parameter int SAMPLE_W = 32,
   parameter int ADDR_W = 18
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_frame_stb,
   input wire logic rx_block_start,
   input wire logic rx_cs_right,
   input wire logic rx_userbits_left,
   input wire logic rx_userbits_right,
   input wire logic rx_validity_left,
   input wire logic rx_validity_right,
   input wire logic rx_parity_left,
   input wire logic rx_parity_right,
   input wire logic tx_frame_tick,
   input wire logic [SAMPLE_W-1:0] tx_sample_left,
   input wire logic [SAMPLE_W-1:0] tx_sample_right,
   output logic [23:0] tx_word_left,
   output logic [23:0] tx_word_right,
   output logic tx_word_valid,
   output satc_pkg::satc_wlen_e tx_word_len,
   output logic tx_output_on,
   output logic transmitter_power_on,
   output logic aux_block_complete_flag,
   output logic irq
);
   import satc_pkg::*;

   // =======================================================================
   // Helpers.
   // =======================================================================
   function automatic satc_word_t merge16(input satc_word_t old, input logic [31:0] data,
                                          input logic [3:0] strb);
      satc_word_t r;
      r = old;
      if (strb[0]) begin
         r[7:0] = data[7:0];
      end
      if (strb[1]) begin
         r[15:8] = data[15:8];
      end
      return r;
   endfunction : merge16

   function automatic logic [15:0] bank_base(input int b);
      return `SATC_IDX_CS_R + 16'(b) * `SATC_BANK_STRIDE;
   endfunction : bank_base

   // =======================================================================
   // Receiver capture banks.
   // =======================================================================
   logic [`SATC_NBANKS-1:0] rx_bits;
   logic [191:0] bank_q [`SATC_NBANKS];
   logic [191:0] bank_d [`SATC_NBANKS];
   logic [7:0] frame_cnt_q;
   logic [7:0] frame_cnt_d;
   logic [7:0] frame_idx;
   logic rdy_q;
   logic rdy_d;
   logic ev_done;
   logic ev_sync;

   assign rx_bits = {rx_parity_right, rx_parity_left, rx_validity_right,
                     rx_validity_left, rx_userbits_right, rx_userbits_left, rx_cs_right};
   assign frame_idx = rx_block_start ? 8'h00 : frame_cnt_q;

   // The block-start marker resynchronises the counter so a lost frame only
   // corrupts one block, never every block after it.
   always_comb begin
      frame_cnt_d = frame_cnt_q;
      rdy_d = rdy_q;
      ev_done = 1'b0;
      ev_sync = 1'b0;
      if (rx_frame_stb) begin
         ev_sync = rx_block_start && (frame_cnt_q != 8'h00);
         if (frame_idx == `SATC_LAST_FRAME) begin
            frame_cnt_d = 8'h00;
            rdy_d = 1'b1;
            ev_done = 1'b1;
         end else begin
            frame_cnt_d = frame_idx + 8'h01;
            if (frame_idx == 8'h00) begin
               rdy_d = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_cnt_q <= 8'h00;
         rdy_q <= 1'b0;
      end else begin
         frame_cnt_q <= frame_cnt_d;
         rdy_q <= rdy_d;
      end
   end

   // Bank order: right status, user left/right, validity left/right, parity
   // left/right.
   for (genvar g = 0; g < `SATC_NBANKS; g++) begin : g_bank
      always_comb begin
         bank_d[g] = bank_q[g];
         if (rx_frame_stb) begin
            bank_d[g][frame_idx] = rx_bits[g];
         end
      end
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            bank_q[g] <= '0;
         end else begin
            bank_q[g] <= bank_d[g];
         end
      end
   end

   // =======================================================================
   // Read decode.
   // =======================================================================
   function automatic logic [16:0] read_reg(input logic [15:0] idx, input satc_word_t en,
                                            input satc_word_t ctrl, input satc_word_t pwr,
                                            input satc_word_t ist, input satc_word_t ien,
                                            input logic rdy);
      logic [16:0] r;
      logic [3:0] w;
      r = {1'b1, 16'h0000};
      w = idx[3:0];
      for (int b = 0; b < `SATC_NBANKS; b++) begin
         if (idx >= bank_base(b) && idx < bank_base(b) + 16'(`SATC_BANK_WORDS)) begin
            r = {1'b0, bank_q[b][16*w +: 16]};
         end
      end
      case (idx)
         `SATC_IDX_RDY: r = {1'b0, 15'h0000, rdy};
         `SATC_IDX_TX_EN: r = {1'b0, en};
         `SATC_IDX_TX_CTRL: r = {1'b0, ctrl};
         `SATC_IDX_PWR: r = {1'b0, pwr};
         `SATC_IDX_IRQ_STAT: r = {1'b0, ist};
         `SATC_IDX_IRQ_EN: r = {1'b0, ien};
         `SATC_IDX_IRQ_CLR: r = {1'b0, 16'h0000};
         default: r = r;
      endcase
      return r;
   endfunction : read_reg

   function automatic logic is_mapped(input logic [15:0] idx);
      logic m;
      m = 1'b0;
      for (int b = 0; b < `SATC_NBANKS; b++) begin
         if (idx >= bank_base(b) && idx < bank_base(b) + 16'(`SATC_BANK_WORDS)) begin
            m = 1'b1;
         end
      end
      case (idx)
         `SATC_IDX_RDY, `SATC_IDX_TX_EN, `SATC_IDX_TX_CTRL, `SATC_IDX_PWR,
         `SATC_IDX_IRQ_STAT, `SATC_IDX_IRQ_EN, `SATC_IDX_IRQ_CLR: m = 1'b1;
         default: m = m;
      endcase
      return m;
   endfunction : is_mapped

   // =======================================================================
   // Control registers and the write channel.
   // =======================================================================
   satc_word_t en_q, en_d, ctrl_q, ctrl_d, pwr_q, pwr_d;
   satc_word_t ist_q, ist_d, ien_q, ien_d;
   logic [15:0] aw_idx_q, aw_idx_d;
   logic [31:0] wdat_q, wdat_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic awready_d, wready_d, bvalid_d, irq_d;
   logic [1:0] bresp_d;
   logic do_write;
   satc_word_t clr;

   assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;

   always_comb begin
      aw_idx_d = aw_idx_q;
      wdat_d = wdat_q;
      wstrb_d = wstrb_q;
      aw_full_d = aw_full_q;
      w_full_d = w_full_q;
      bvalid_d = s_axi_bvalid;
      bresp_d = s_axi_bresp;
      en_d = en_q;
      ctrl_d = ctrl_q;
      pwr_d = pwr_q;
      ien_d = ien_q;
      clr = 16'h0000;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_idx_d = s_axi_awaddr[17:2];
         aw_full_d = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wdat_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
         w_full_d = 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (do_write) begin
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = is_mapped(aw_idx_q) ? `SATC_RESP_OKAY : `SATC_RESP_SLVERR;
         // Capture banks, ready flag and status take no write at all.
         case (aw_idx_q)
            `SATC_IDX_TX_EN: en_d = merge16(en_q, wdat_q, wstrb_q);
            `SATC_IDX_TX_CTRL: ctrl_d = merge16(ctrl_q, wdat_q, wstrb_q);
            `SATC_IDX_PWR: pwr_d = merge16(pwr_q, wdat_q, wstrb_q);
            `SATC_IDX_IRQ_EN: ien_d = merge16(ien_q, wdat_q, wstrb_q);
            `SATC_IDX_IRQ_CLR: clr = merge16(16'h0000, wdat_q, wstrb_q);
            default: clr = 16'h0000;
         endcase
      end
      // A new event wins over a clear in the same cycle.
      ist_d = ist_q & ~clr;
      ist_d[`SATC_IRQ_DONE_BIT] = ist_d[`SATC_IRQ_DONE_BIT] | ev_done;
      ist_d[`SATC_IRQ_SYNC_BIT] = ist_d[`SATC_IRQ_SYNC_BIT] | ev_sync;
      irq_d = |(ist_d & ien_d);
      awready_d = !aw_full_d && !bvalid_d;
      wready_d = !w_full_d && !bvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_q <= `SATC_RST_ZERO;
         ctrl_q <= `SATC_RST_ZERO;
         pwr_q <= `SATC_PWR_RST;
         ist_q <= `SATC_RST_ZERO;
         ien_q <= `SATC_RST_ZERO;
         aw_idx_q <= 16'h0000;
         wdat_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SATC_RESP_OKAY;
         irq <= 1'b0;
         transmitter_power_on <= 1'b0;
         aux_block_complete_flag <= 1'b0;
      end else begin
         en_q <= en_d;
         ctrl_q <= ctrl_d;
         pwr_q <= pwr_d;
         ist_q <= ist_d;
         ien_q <= ien_d;
         aw_idx_q <= aw_idx_d;
         wdat_q <= wdat_d;
         wstrb_q <= wstrb_d;
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         s_axi_awready <= awready_d;
         s_axi_wready <= wready_d;
         s_axi_bvalid <= bvalid_d;
         s_axi_bresp <= bresp_d;
         irq <= irq_d;
         transmitter_power_on <= pwr_d[`SATC_TXPWR_BIT];
         aux_block_complete_flag <= rdy_d;
      end
   end

   // =======================================================================
   // Read channel.
   // =======================================================================
   logic arready_d, rvalid_d;
   logic [31:0] rdata_d;
   logic [1:0] rresp_d;
   logic [16:0] rd;

   always_comb begin
      arready_d = s_axi_arready;
      rvalid_d = s_axi_rvalid;
      rdata_d = s_axi_rdata;
      rresp_d = s_axi_rresp;
      rd = read_reg(s_axi_araddr[17:2], en_q, ctrl_q, pwr_q, ist_q, ien_q, rdy_q);
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_d = 1'b0;
         arready_d = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         arready_d = 1'b0;
         rdata_d = {16'h0000, rd[15:0]};
         rresp_d = rd[16] ? `SATC_RESP_SLVERR : `SATC_RESP_OKAY;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `SATC_RESP_OKAY;
      end else begin
         s_axi_arready <= arready_d || (!s_axi_arready && !s_axi_rvalid && !rvalid_d);
         s_axi_rvalid <= rvalid_d;
         s_axi_rdata <= rdata_d;
         s_axi_rresp <= rresp_d;
      end
   end

   // =======================================================================
   // Transmitter word path.
   // =======================================================================
   satc_wlen_e auto_len, eff_len, len_d;
   logic [23:0] mask, word_l_d, word_r_d;
   logic on_d, valid_d;
   logic [2:0] cs_code;

   assign cs_code = bank_q[0][`SATC_CS_LEN_LO +: 3];

   // Only the lengths this transmitter can send are decoded; any other code
   // falls back to the stream's maximum.
   always_comb begin
      if (bank_q[0][`SATC_CS_MAXLEN_BIT]) begin
         auto_len = (cs_code == `SATC_CS_CODE_SHORT) ? SATC_WL_20 : SATC_WL_24;
      end else begin
         auto_len = (cs_code == `SATC_CS_CODE_SHORT) ? SATC_WL_16 : SATC_WL_20;
      end
   end

   always_comb begin
      eff_len = satc_wlen_e'(ctrl_q[1:0]);
      if (eff_len == SATC_WL_AUTO) begin
         eff_len = auto_len;
      end
      case (eff_len)
         SATC_WL_20: mask = `SATC_MASK_20;
         SATC_WL_16: mask = `SATC_MASK_16;
         default: mask = `SATC_MASK_24;
      endcase
      len_d = tx_word_len;
      on_d = tx_output_on;
      word_l_d = tx_word_left;
      word_r_d = tx_word_right;
      valid_d = 1'b0;
      if (tx_frame_tick) begin
         len_d = eff_len;
         on_d = en_q[`SATC_TX_OUTPUT_ON_BIT];
         valid_d = 1'b1;
         // Top bits kept, low bits cut; never wider than the line allows.
         word_l_d = tx_sample_left[SAMPLE_W-1 -: `SATC_MAX_WL] & mask;
         word_r_d = tx_sample_right[SAMPLE_W-1 -: `SATC_MAX_WL] & mask;
         if (!en_q[`SATC_TX_OUTPUT_ON_BIT]) begin
            word_l_d = 24'h000000;
            word_r_d = 24'h000000;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_word_len <= SATC_WL_24;
         tx_output_on <= 1'b0;
         tx_word_left <= 24'h000000;
         tx_word_right <= 24'h000000;
         tx_word_valid <= 1'b0;
      end else begin
         tx_word_len <= len_d;
         tx_output_on <= on_d;
         tx_word_left <= word_l_d;
         tx_word_right <= word_r_d;
         tx_word_valid <= valid_d;
      end
   end

endmodule : satc_top

// *** test/satc_top_sva.sv ***
`timescale 1ns/1ps
// ========================================
// Transmit framing and capture flag checks.
// ========================================
module satc_top_chk
   import satc_pkg::*;
#(
   parameter int SAMPLE_W = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic rx_frame_stb,
   input wire logic rx_block_start,
   input wire logic tx_frame_tick,
   input wire logic [SAMPLE_W-1:0] tx_sample_left,
   input wire logic [SAMPLE_W-1:0] tx_sample_right,
   input wire logic [23:0] tx_word_left,
   input wire logic [23:0] tx_word_right,
   input wire logic tx_word_valid,
   input wire satc_pkg::satc_wlen_e tx_word_len,
   input wire logic tx_output_on,
   input wire logic aux_block_complete_flag
);
   logic [15:0] top_l;
   logic [15:0] top_r;
   assign top_l = tx_sample_left[SAMPLE_W-1 -: 16];
   assign top_r = tx_sample_right[SAMPLE_W-1 -: 16];
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_word_after_tick;
      tx_frame_tick |=> tx_word_valid;
   endproperty
   a_word_after_tick: assert property (p_word_after_tick) else $error("no word after tick");
   property p_no_stray_word;
      !tx_frame_tick |=> !tx_word_valid;
   endproperty
   a_no_stray_word: assert property (p_no_stray_word) else $error("word without tick");
   property p_hold_between;
      !tx_frame_tick |=> $stable(tx_word_left) && $stable(tx_word_len) && $stable(tx_output_on);
   endproperty
   a_hold_between: assert property (p_hold_between) else $error("output changed mid frame");
   property p_off_zero;
      tx_word_valid && !tx_output_on |-> tx_word_left == 24'h000000 && tx_word_right == 24'h000000;
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("nonzero word while off");
   property p_len_legal;
      tx_word_valid |-> tx_word_len != SATC_WL_AUTO;
   endproperty
   a_len_legal: assert property (p_len_legal) else $error("auto code on length output");
   property p_cut16;
      tx_word_valid && tx_word_len == SATC_WL_16 |-> tx_word_left[7:0] == 8'h00 && tx_word_right[7:0] == 8'h00;
   endproperty
   a_cut16: assert property (p_cut16) else $error("16 bit word has low bits");
   property p_cut20;
      tx_word_valid && tx_word_len == SATC_WL_20 |-> tx_word_left[3:0] == 4'h0 && tx_word_right[3:0] == 4'h0;
   endproperty
   a_cut20: assert property (p_cut20) else $error("20 bit word has low bits");
   property p_msb_kept;
      tx_word_valid && tx_output_on |-> tx_word_left[23:8] == $past(top_l) && tx_word_right[23:8] == $past(top_r);
   endproperty
   a_msb_kept: assert property (p_msb_kept) else $error("sample top bits lost");
   property p_flag_clear;
      rx_frame_stb && rx_block_start |=> !aux_block_complete_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag kept at new block");
endmodule : satc_top_chk

bind satc_top satc_top_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.aclk, .aresetn, .rx_frame_stb,
   .rx_block_start, .tx_frame_tick, .tx_sample_left, .tx_sample_right, .tx_word_left,
   .tx_word_right, .tx_word_valid, .tx_word_len, .tx_output_on, .aux_block_complete_flag);

// *** test/satc_src_model.sv ***
`timescale 1ns/1ps
// ========================================
// Far side: decoded receive frames and the transmit frame clock.
// ========================================
module satc_src_model (
   input wire logic aclk,
   output logic rx_frame_stb,
   output logic rx_block_start,
   output logic [6:0] rx_bits,
   output logic tx_frame_tick,
   output logic [31:0] smp_l,
   output logic [31:0] smp_r
);
   // Lines outside a strobe show the inverse, so a late sample cannot pass by luck.
   function automatic logic pat(input int b, input int n);
      return ((n * (b + 1) + b) % 7) < 3;
   endfunction : pat
   initial begin
      rx_frame_stb = 1'b0;
      rx_block_start = 1'b0;
      rx_bits = 7'h00;
      tx_frame_tick = 1'b0;
      smp_l = 32'h00000000;
      smp_r = 32'h00000000;
   end
   task automatic send_block(input int nf);
      for (int n = 0; n < nf; n++) begin
         @(posedge aclk);
         rx_frame_stb <= 1'b1;
         rx_block_start <= (n == 0);
         for (int b = 0; b < 7; b++) begin
            rx_bits[b] <= pat(b, n);
         end
      end
      @(posedge aclk);
      rx_frame_stb <= 1'b0;
      rx_block_start <= 1'b0;
      rx_bits <= ~rx_bits;
   endtask : send_block
   task automatic tick(input logic [31:0] l, input logic [31:0] r);
      @(posedge aclk);
      tx_frame_tick <= 1'b1;
      smp_l <= l;
      smp_r <= r;
      @(posedge aclk);
      tx_frame_tick <= 1'b0;
      smp_l <= ~l;
      smp_r <= ~r;
   endtask : tick
endmodule : satc_src_model

// *** test/satc_top_tb.sv ***
`timescale 1ns/1ps
`include "satc_defs.svh"
// ========================================
// Register, capture and transmit sequences.
// ========================================
module satc_top_tb;
   import satc_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, smp_l, smp_r, s;
   logic [1:0] s_axi_bresp, s_axi_rresp, al;
   logic rx_frame_stb, rx_block_start, tx_frame_tick, tx_word_valid, tx_output_on;
   logic transmitter_power_on, aux_block_complete_flag, irq;
   logic [6:0] rx_bits;
   logic [23:0] tx_word_left, tx_word_right;
   logic [15:0] e;
   satc_wlen_e tx_word_len;
   int n_errors, samples_checked;
   satc_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .rx_frame_stb, .rx_block_start, .rx_cs_right(rx_bits[0]), .rx_userbits_left(rx_bits[1]),
      .rx_userbits_right(rx_bits[2]), .rx_validity_left(rx_bits[3]),
      .rx_validity_right(rx_bits[4]), .rx_parity_left(rx_bits[5]), .rx_parity_right(rx_bits[6]),
      .tx_frame_tick, .tx_sample_left(smp_l), .tx_sample_right(smp_r), .tx_word_left,
      .tx_word_right, .tx_word_valid, .tx_word_len, .tx_output_on, .transmitter_power_on,
      .aux_block_complete_flag, .irq);
   satc_src_model src (.aclk, .rx_frame_stb, .rx_block_start, .rx_bits, .tx_frame_tick,
      .smp_l, .smp_r);
   always #20 aclk = ~aclk;
   task automatic report_and_stop;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic tmo(input int n);
      if (n >= 50) begin
         n_errors++;
         report_and_stop();
      end
   endtask : tmo
   task automatic axw(input logic [15:0] idx, input logic [15:0] d, input logic [1:0] er);
      int n;
      logic aw, wd;
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1'b1;
      wd = 1'b1;
      n = 0;
      while (n < 50 && (aw || wd || !s_axi_bvalid)) begin
         @(posedge aclk);
         n++;
         if (aw && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            aw = 1'b0;
         end
         if (wd && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            wd = 1'b0;
         end
      end
      tmo(n);
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
   endtask : axw
   task automatic rd(input logic [15:0] idx, input logic [15:0] x, input logic [1:0] er);
      int n;
      logic ar;
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      ar = 1'b1;
      n = 0;
      while (n < 50 && (ar || !s_axi_rvalid)) begin
         @(posedge aclk);
         n++;
         if (ar && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            ar = 1'b0;
         end
      end
      tmo(n);
      chk($sformatf("reg %h", idx), s_axi_rdata, {16'h0000, x});
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic txc(input logic [31:0] v, input logic [1:0] wl, input logic on);
      logic [23:0] m;
      m = (wl == 2'h2) ? 24'hFFFF00 : (wl == 2'h1) ? 24'hFFFFF0 : 24'hFFFFFF;
      src.tick(v, ~v);
      @(negedge aclk);
      chk("valid", {31'h0, tx_word_valid}, 32'h1);
      chk("len", {30'h0, tx_word_len}, {30'h0, wl});
      chk("on", {31'h0, tx_output_on}, {31'h0, on});
      chk("left", {8'h00, tx_word_left}, on ? {8'h00, v[31:8] & m} : 32'h0);
      chk("right", {8'h00, tx_word_right}, on ? {8'h00, ~v[31:8] & m} : 32'h0);
   endtask : txc
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 18'h00000;
      s_axi_araddr = 18'h00000;
      s_axi_wdata = 32'h00000000;
      n_errors = 0;
      samples_checked = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`SATC_IDX_TX_EN, 16'h0000, `SATC_RESP_OKAY);
      rd(`SATC_IDX_TX_CTRL, 16'h0000, `SATC_RESP_OKAY);
      rd(16'h0001, 16'h0000, `SATC_RESP_SLVERR);
      axw(16'h0001, 16'hFFFF, `SATC_RESP_SLVERR);
      for (int b = 0; b < 7; b++) begin
         rd(16'(`SATC_IDX_CS_R + b * 16 + 11), 16'h0000, `SATC_RESP_OKAY);
      end
      // A block before the transmit checks, so auto length has channel status to use.
      src.send_block(192);
      for (int b = 0; b < 7; b++) begin
         for (int k = 0; k < 12; k++) begin
            for (int i = 0; i < 16; i++) begin
               e[i] = src.pat(b, k * 16 + i);
            end
            rd(16'(`SATC_IDX_CS_R + b * 16 + k), e, `SATC_RESP_OKAY);
         end
      end
      axw(16'(`SATC_IDX_PB_R + 11), 16'hFFFF, `SATC_RESP_OKAY);
      rd(16'(`SATC_IDX_PB_R + 11), e, `SATC_RESP_OKAY);
      rd(`SATC_IDX_RDY, 16'h0001, `SATC_RESP_OKAY);
      chk("flag", {31'h0, aux_block_complete_flag}, 32'h1);
      chk("irq", {31'h0, irq}, 32'h0);
      axw(`SATC_IDX_IRQ_EN, 16'h0001, `SATC_RESP_OKAY);
      chk("irq", {31'h0, irq}, 32'h1);
      axw(`SATC_IDX_IRQ_EN, 16'h0000, `SATC_RESP_OKAY);
      chk("irq", {31'h0, irq}, 32'h0);
      axw(`SATC_IDX_IRQ_EN, 16'h0001, `SATC_RESP_OKAY);
      axw(`SATC_IDX_IRQ_CLR, 16'h0001, `SATC_RESP_OKAY);
      chk("irq", {31'h0, irq}, 32'h0);
      rd(`SATC_IDX_IRQ_STAT, 16'h0000, `SATC_RESP_OKAY);
      axw(`SATC_IDX_PWR, 16'h0004, `SATC_RESP_OKAY);
      chk("power", {31'h0, transmitter_power_on}, 32'h1);
      txc(32'hAABBCCDD, 2'h0, 1'b0);
      chk("power", {31'h0, transmitter_power_on}, 32'h1);
      axw(`SATC_IDX_TX_EN, 16'h0001, `SATC_RESP_OKAY);
      rd(`SATC_IDX_TX_EN, 16'h0001, `SATC_RESP_OKAY);
      s = 32'hFFFFFFFF;
      for (int m = 0; m < 3; m++) begin
         axw(`SATC_IDX_TX_CTRL, 16'(m), `SATC_RESP_OKAY);
         chk("len", {30'h0, tx_word_len}, (m == 0) ? 32'h0 : 32'(m - 1));
         txc(s, 2'(m), 1'b1);
         s = 32'h9A5C3E71;
      end
      al = src.pat(0, 32) ? 2'h0 : 2'h1;
      if ({src.pat(0, 35), src.pat(0, 34), src.pat(0, 33)} == 3'h1) al = al + 2'h1;
      axw(`SATC_IDX_TX_CTRL, 16'h0003, `SATC_RESP_OKAY);
      txc(s, al, 1'b1);
      axw(`SATC_IDX_TX_EN, 16'h0000, `SATC_RESP_OKAY);
      txc(s, al, 1'b0);
      axw(`SATC_IDX_PWR, 16'h0000, `SATC_RESP_OKAY);
      chk("power", {31'h0, transmitter_power_on}, 32'h0);
      src.send_block(1);
      rd(`SATC_IDX_RDY, 16'h0000, `SATC_RESP_OKAY);
      chk("flag", {31'h0, aux_block_complete_flag}, 32'h0);
      // A start marker in mid-block must raise the sync error status bit.
      src.send_block(1);
      rd(`SATC_IDX_IRQ_STAT, 16'h0002, `SATC_RESP_OKAY);
      axw(`SATC_IDX_IRQ_EN, 16'h0002, `SATC_RESP_OKAY);
      chk("irq", {31'h0, irq}, 32'h1);
      report_and_stop();
   end
endmodule : satc_top_tb
